// [design/eeprom_access_controller.sv]
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module eeprom_access_controller #(
    parameter bit LARGE_ARRAY = 1'b1,
    parameter int CW = 16,
    parameter int ATOMIC_TICKS = eeprom_pkg::ATOMIC_TICKS,
    parameter int SPLIT_TICKS = eeprom_pkg::SPLIT_TICKS
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic por_n_i,
    input wire logic osc_i,
    input wire logic [eeprom_pkg::REG_AW-1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [7:0] reg_rdata_o,
    output logic cpu_stall_o,
    output logic ready_irq_o,
    output logic busy_o
);
    localparam int ADDR_W = LARGE_ARRAY ? 9 : 8;

    function automatic logic [2:0] dec_sat(input logic [2:0] v);
        dec_sat = (v == 3'h0) ? 3'h0 : v - 3'h1;
    endfunction

    function automatic eeprom_pkg::array_op_t mode_to_op(input logic [1:0] m);
        case (m)
            eeprom_pkg::MODE_ATOMIC: mode_to_op = eeprom_pkg::ARR_ATOMIC;
            eeprom_pkg::MODE_ERASE: mode_to_op = eeprom_pkg::ARR_ERASE;
            eeprom_pkg::MODE_WRITE: mode_to_op = eeprom_pkg::ARR_WRITE;
            default: mode_to_op = eeprom_pkg::ARR_NONE;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Register decode

    logic wr_ctrl;
    logic wr_data;
    logic wr_addr_lo;
    logic wr_addr_hi;
    logic busy;
    logic arm_on;
    logic rd_go;
    logic prog_go;
    logic arm_set;
    logic [8:0] addr_reg;
    logic [7:0] data_reg;

    assign wr_ctrl = reg_we_i && (reg_addr_i == eeprom_pkg::CTRL_OFF);
    assign wr_data = reg_we_i && (reg_addr_i == eeprom_pkg::DATA_OFF);
    assign wr_addr_lo = reg_we_i && (reg_addr_i == eeprom_pkg::ADDR_LO_OFF) && !busy;
    assign wr_addr_hi = reg_we_i && (reg_addr_i == eeprom_pkg::ADDR_HI_OFF) && !busy;
    assign arm_set = wr_ctrl && reg_wdata_i[eeprom_pkg::BIT_ARM];

    ////////////////////////////////////////////////////////////////////////////////
    // Power-on domain: survives a system reset, except mode_reg while the engine is idle

    eeprom_pkg::prog_state_t state_reg;
    eeprom_pkg::prog_state_t state_next;
    logic [1:0] mode_reg;
    logic [1:0] mode_next;
    logic [ADDR_W-1:0] op_addr_reg;
    logic [7:0] op_data_reg;
    eeprom_pkg::array_op_t op_kind_reg;
    logic rst_sync1_reg;
    logic rst_sync2_reg;
    logic osc_s1_reg;
    logic osc_s2_reg;
    logic osc_s3_reg;
    logic osc_tick;
    logic timer_done;
    logic [CW-1:0] load_count;

    assign busy = (state_reg != eeprom_pkg::PROG_IDLE);
    assign busy_o = busy;
    assign osc_tick = osc_s2_reg && !osc_s3_reg;

    // System reset is seen synchronously here, so the engine keeps running through it
    always_ff @(posedge clock_i or negedge por_n_i)
    begin
        if (!por_n_i)
        begin
            rst_sync1_reg <= 1'b0;
            rst_sync2_reg <= 1'b0;
            osc_s1_reg <= 1'b0;
            osc_s2_reg <= 1'b0;
            osc_s3_reg <= 1'b0;
        end
        else
        begin
            rst_sync1_reg <= rst_n_i;
            rst_sync2_reg <= rst_sync1_reg;
            osc_s1_reg <= osc_i;
            osc_s2_reg <= osc_s1_reg;
            osc_s3_reg <= osc_s2_reg;
        end
    end

    // Mode reset on system reset is skipped while the engine is busy
    always_comb
    begin
        mode_next = mode_reg;
        if (!busy && !rst_sync2_reg)
            mode_next = eeprom_pkg::MODE_RESET;
        else if (wr_ctrl && !busy)
            mode_next = {reg_wdata_i[eeprom_pkg::BIT_MODE_HI], reg_wdata_i[eeprom_pkg::BIT_MODE_LO]};
    end

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            eeprom_pkg::PROG_IDLE: if (prog_go) state_next = eeprom_pkg::PROG_RUN;
            eeprom_pkg::PROG_RUN: if (timer_done) state_next = eeprom_pkg::PROG_COMMIT;
            eeprom_pkg::PROG_COMMIT: state_next = eeprom_pkg::PROG_IDLE;
            default: state_next = eeprom_pkg::PROG_IDLE;
        endcase
    end

    always_ff @(posedge clock_i or negedge por_n_i)
    begin
        if (!por_n_i)
        begin
            state_reg <= eeprom_pkg::PROG_IDLE;
            mode_reg <= eeprom_pkg::MODE_RESET;
        end
        else
        begin
            state_reg <= state_next;
            mode_reg <= mode_next;
        end
    end

    always_ff @(posedge clock_i or negedge por_n_i)
    begin
        if (!por_n_i)
        begin
            op_addr_reg <= '0;
            op_data_reg <= eeprom_pkg::DATA_RESET;
            op_kind_reg <= eeprom_pkg::ARR_NONE;
        end
        else if (prog_go)
        begin
            op_addr_reg <= addr_reg[ADDR_W-1:0];
            op_data_reg <= data_reg;
            op_kind_reg <= mode_to_op(mode_reg);
        end
    end

    // Atomic takes the long count, split modes the short one
    assign load_count = (mode_reg == eeprom_pkg::MODE_ATOMIC) ? CW'(ATOMIC_TICKS) : CW'(SPLIT_TICKS);

    eeprom_prog_timer #(.CW(CW)) u_timer (
        .clock_i(clock_i),
        .por_n_i(por_n_i),
        .load_i(prog_go),
        .count_i(load_count),
        .tick_i(osc_tick),
        .done_o(timer_done)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Array access

    nvm_array_if #(.ADDR_W(ADDR_W)) arr_if ();

    assign arr_if.rd_en = rd_go;
    assign arr_if.op = (state_reg == eeprom_pkg::PROG_COMMIT) ? op_kind_reg : eeprom_pkg::ARR_NONE;
    assign arr_if.addr = busy ? op_addr_reg : addr_reg[ADDR_W-1:0];
    assign arr_if.wdata = op_data_reg;

    eeprom_byte_array #(.ADDR_W(ADDR_W)) u_array (
        .clock_i(clock_i),
        .por_n_i(por_n_i),
        .arr(arr_if.array_side)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // CPU domain registers

    logic rie_reg;
    logic [2:0] arm_cnt_reg;
    logic [2:0] arm_cnt_next;
    logic [2:0] stall_cnt_reg;
    logic [2:0] stall_cnt_next;
    logic read_pend_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [7:0] ctrl_view;
    logic addr_hi_bit;

    assign arm_on = (arm_cnt_reg != 3'h0);
    assign rd_go = wr_ctrl && reg_wdata_i[eeprom_pkg::BIT_READ] && !busy;
    // A reserved mode leaves the start bit without effect
    assign prog_go = wr_ctrl && reg_wdata_i[eeprom_pkg::BIT_START] && arm_on && !busy
        && (mode_reg != eeprom_pkg::MODE_RESERVED);

    // Arm window restarts on every arm write
    assign arm_cnt_next = arm_set ? eeprom_pkg::ARM_WINDOW_CYC : dec_sat(arm_cnt_reg);

    always_comb
    begin
        stall_cnt_next = dec_sat(stall_cnt_reg);
        if (rd_go)
            stall_cnt_next = eeprom_pkg::READ_STALL_CYC;
        else if (prog_go)
            stall_cnt_next = eeprom_pkg::PROG_STALL_CYC;
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            arm_cnt_reg <= 3'h0;
            stall_cnt_reg <= 3'h0;
            rie_reg <= 1'b0;
            read_pend_reg <= 1'b0;
        end
        else
        begin
            arm_cnt_reg <= arm_cnt_next;
            stall_cnt_reg <= stall_cnt_next;
            read_pend_reg <= rd_go;
            if (wr_ctrl)
                rie_reg <= reg_wdata_i[eeprom_pkg::BIT_RIE];
        end
    end

    // The address is frozen while busy so the running op keeps its target
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            addr_reg <= eeprom_pkg::ADDR_RESET;
        else if (wr_addr_lo)
            addr_reg[7:0] <= reg_wdata_i;
        else if (wr_addr_hi)
            addr_reg[8] <= reg_wdata_i[0] & LARGE_ARRAY;
    end

    // Array data wins over a CPU write landing in the same cycle, but the CPU is stalled then
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            data_reg <= eeprom_pkg::DATA_RESET;
        else if (read_pend_reg)
            data_reg <= arr_if.rdata;
        else if (wr_data)
            data_reg <= reg_wdata_i;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read back

    assign addr_hi_bit = addr_reg[8] & LARGE_ARRAY;
    assign ctrl_view = {2'h0, mode_reg, rie_reg, arm_on, busy, 1'b0};

    // Read data is zero outside the cycle after a read strobe
    always_comb
    begin
        rdata_next = 8'h00;
        if (reg_re_i)
        begin
            case (reg_addr_i)
                eeprom_pkg::CTRL_OFF: rdata_next = ctrl_view;
                eeprom_pkg::DATA_OFF: rdata_next = data_reg;
                eeprom_pkg::ADDR_LO_OFF: rdata_next = addr_reg[7:0];
                eeprom_pkg::ADDR_HI_OFF: rdata_next = {7'h00, addr_hi_bit};
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rdata_reg <= 8'h00;
        else
            rdata_reg <= rdata_next;
    end

    assign reg_rdata_o = rdata_reg;
    assign cpu_stall_o = (stall_cnt_reg != 3'h0);
    // Level request; the global interrupt enable is applied by the core
    assign ready_irq_o = rie_reg && !busy;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i || !por_n_i);

    sequence arm_hold_s;
        arm_on [*4];
    endsequence

    sequence read_stall_s;
        cpu_stall_o [*4] ##1 !cpu_stall_o;
    endsequence

    a_read_stall_len: assert property (rd_go |=> read_stall_s)
        else $error("read stall length wrong");
    a_read_stall_seq: assert property (rd_go |=> cpu_stall_o [*4])
        else $error("read did not stall four cycles");
    a_prog_stall_len: assert property (prog_go |=> cpu_stall_o [*2] ##1 !cpu_stall_o)
        else $error("start did not stall two cycles");
    a_arm_window_close: assert property ((arm_set ##1 !arm_set [*4]) |=> !arm_on)
        else $error("arm bit outlived its window");
    a_arm_window_open: assert property (arm_set |=> arm_hold_s)
        else $error("arm bit dropped early");
    a_start_needs_arm: assert property (prog_go |-> $past(arm_set, 1) || $past(arm_set, 2)
        || $past(arm_set, 3) || $past(arm_set, 4))
        else $error("start taken without recent arm");
    a_busy_until_done: assert property (busy && !timer_done && state_reg == eeprom_pkg::PROG_RUN
        |=> busy)
        else $error("busy dropped before timer expiry");
    a_busy_clear_cause: assert property ($fell(busy) |-> $past(state_reg == eeprom_pkg::PROG_COMMIT)
        && $past(timer_done, 2))
        else $error("busy cleared without completion");
    a_mode_frozen: assert property (busy && $past(busy) |-> $stable(mode_reg))
        else $error("mode bits changed while busy");
    // Look at the effects, not the gating terms, so a broken gate shows up
    a_busy_refuses: assert property (busy
        |=> $stable(addr_reg) && !$rose(cpu_stall_o))
        else $error("operation accepted while busy");
    a_reserved_start: assert property (wr_ctrl && reg_wdata_i[eeprom_pkg::BIT_START] && !busy
        && mode_reg == eeprom_pkg::MODE_RESERVED |=> !busy)
        else $error("reserved mode started an operation");
    a_read_data_load: assert property (rd_go |=> ##1 data_reg == $past(arr_if.rdata))
        else $error("read data not loaded");
    a_addr_hi_reserved: assert property (reg_re_i && reg_addr_i == eeprom_pkg::ADDR_HI_OFF
        |=> reg_rdata_o[7:1] == 7'h00)
        else $error("reserved address bits not zero");
    a_irq_gating: assert property (ready_irq_o |-> rie_reg && state_reg == eeprom_pkg::PROG_IDLE)
        else $error("ready interrupt outside ready state");
    a_commit_kind: assert property (prog_go && mode_reg == eeprom_pkg::MODE_ATOMIC
        |=> op_kind_reg == eeprom_pkg::ARR_ATOMIC)
        else $error("atomic mode not latched");
endmodule
`default_nettype wire

// [design/eeprom_pkg.sv]
// Overview of operation
// - Atomic mode erases the byte then writes it as one operation.
// - Erase-only and write-only modes run as separate shorter operations.
// - The two mode bits in the control register pick the operation.
// - The ready interrupt is gated by its own enable bit.
// - Read strobe reads the addressed byte and stalls the CPU four cycles.
// - The byte read appears in the data register.
// - A start counts only within four cycles after arming.
// - Starting an erase or write stalls the CPU two cycles.
// - Program-start stays set as busy until the operation ends.
// - While programming, reads and further starts are refused.
// - A programming operation in progress survives a system reset.
// - High address bits 7:1 read zero; bit 0 is address bit 8.
// - Address bit 8 exists only in the 512-byte variant.
// - Modes: 00 atomic 3.4 ms, 01 erase 1.8 ms, 10 write 1.8 ms, 11 reserved.
// - Arm clears itself after four cycles; start without arm does nothing.
// - Mode bit writes are ignored while busy.
// - Ready interrupt is raised whenever enabled and not busy.
package eeprom_pkg;

    localparam int REG_AW = 2;
    localparam logic [1:0] CTRL_OFF = 2'h0;
    localparam logic [1:0] DATA_OFF = 2'h1;
    localparam logic [1:0] ADDR_LO_OFF = 2'h2;
    localparam logic [1:0] ADDR_HI_OFF = 2'h3;

    localparam int BIT_READ = 0;
    localparam int BIT_START = 1;
    localparam int BIT_ARM = 2;
    localparam int BIT_RIE = 3;
    localparam int BIT_MODE_LO = 4;
    localparam int BIT_MODE_HI = 5;

    localparam logic [1:0] MODE_ATOMIC = 2'h0;
    localparam logic [1:0] MODE_ERASE = 2'h1;
    localparam logic [1:0] MODE_WRITE = 2'h2;
    localparam logic [1:0] MODE_RESERVED = 2'h3;

    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [8:0] ADDR_RESET = 9'h000;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    localparam logic [2:0] ARM_WINDOW_CYC = 3'h4;
    localparam logic [2:0] READ_STALL_CYC = 3'h4;
    localparam logic [2:0] PROG_STALL_CYC = 3'h2;

    // Oscillator ticks per operation derived from the printed times
    localparam int OSC_FREQ_KHZ = 8000;
    localparam int ATOMIC_TIME_US = 3400;
    localparam int SPLIT_TIME_US = 1800;
    localparam int ATOMIC_TICKS = ATOMIC_TIME_US * OSC_FREQ_KHZ / 1000;
    localparam int SPLIT_TICKS = SPLIT_TIME_US * OSC_FREQ_KHZ / 1000;

    typedef enum logic [1:0] {
        ARR_NONE = 2'h0,
        ARR_ERASE = 2'h1,
        ARR_WRITE = 2'h2,
        ARR_ATOMIC = 2'h3
    } array_op_t;

    typedef enum logic [1:0] {
        PROG_IDLE = 2'h0,
        PROG_RUN = 2'h1,
        PROG_COMMIT = 2'h3
    } prog_state_t;

endpackage

// [design/nvm_array_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface nvm_array_if #(parameter int ADDR_W = 9);
    logic rd_en;
    eeprom_pkg::array_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport ctrl_side (output rd_en, output op, output addr, output wdata, input rdata);
    modport array_side (input rd_en, input op, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// [design/eeprom_byte_array.sv]
`timescale 1ns/1ns
`default_nettype none
module eeprom_byte_array #(
    parameter int ADDR_W = 9
) (
    input wire logic clock_i,
    input wire logic por_n_i,
    nvm_array_if.array_side arr
);
    logic [7:0] mem [0:(1<<ADDR_W)-1];
    logic [7:0] rdata_reg;

    // Cells only lose charge on write, so an unerased target ends up as the AND
    always_ff @(posedge clock_i)
    begin
        case (arr.op)
            eeprom_pkg::ARR_ERASE: mem[arr.addr] <= eeprom_pkg::ERASED_BYTE;
            eeprom_pkg::ARR_WRITE: mem[arr.addr] <= mem[arr.addr] & arr.wdata;
            eeprom_pkg::ARR_ATOMIC: mem[arr.addr] <= arr.wdata;
            default: ;
        endcase
    end

    always_ff @(posedge clock_i or negedge por_n_i)
    begin
        if (!por_n_i)
            rdata_reg <= eeprom_pkg::DATA_RESET;
        else if (arr.rd_en)
            rdata_reg <= mem[arr.addr];
    end

    assign arr.rdata = rdata_reg;
endmodule
`default_nettype wire

// [design/eeprom_prog_timer.sv]
`timescale 1ns/1ns
`default_nettype none
module eeprom_prog_timer #(
    parameter int CW = 16
) (
    input wire logic clock_i,
    input wire logic por_n_i,
    input wire logic load_i,
    input wire logic [CW-1:0] count_i,
    input wire logic tick_i,
    output logic done_o
);
    logic [CW-1:0] count_reg;
    logic running_reg;
    logic done_reg;
    logic last_tick;

    assign last_tick = running_reg && tick_i && (count_reg == CW'(1));

    always_ff @(posedge clock_i or negedge por_n_i)
    begin
        if (!por_n_i)
        begin
            count_reg <= '0;
            running_reg <= 1'b0;
            done_reg <= 1'b0;
        end
        else
        begin
            done_reg <= last_tick;
            if (load_i)
            begin
                count_reg <= count_i;
                running_reg <= 1'b1;
            end
            else if (running_reg && tick_i)
            begin
                count_reg <= count_reg - CW'(1);
                running_reg <= !last_tick;
            end
        end
    end

    assign done_o = done_reg;
endmodule
`default_nettype wire

// [design/unused_guard_none.sv]
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// [tb/eeprom_access_controller_test.sv]
`timescale 1ns/1ns
`default_nettype none
module eeprom_access_controller_test;
localparam logic [1:0] CT = eeprom_pkg::CTRL_OFF;
localparam logic [1:0] DT = eeprom_pkg::DATA_OFF;
localparam logic [1:0] AL = eeprom_pkg::ADDR_LO_OFF;
localparam logic [1:0] AH = eeprom_pkg::ADDR_HI_OFF;
logic clock_i = 1'b0;
logic rst_n_i = 1'b0;
logic por_n_i = 1'b0;
logic osc_i = 1'b0;
logic reg_we_i = 1'b0;
logic reg_re_i = 1'b0;
logic [1:0] reg_addr_i = 2'h0;
logic [7:0] reg_wdata_i = 8'h00;
wire logic [7:0] reg_rdata_o;
wire logic cpu_stall_o;
wire logic ready_irq_o;
wire logic busy_o;
int miscompares = 0;
int n_checks = 0;
int cyc = 0;
int n;
int t_split;
logic [7:0] model [512];
logic [7:0] rv;
logic [8:0] ra;
logic ie = 1'b0;

////////////////////////////////////////////////////////////////
// Short tick counts keep each programming run to tens of cycles
eeprom_access_controller #(.LARGE_ARRAY(1'b1), .CW(16), .ATOMIC_TICKS(8), .SPLIT_TICKS(4)) DUT (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .por_n_i(por_n_i), .osc_i(osc_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
    .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .cpu_stall_o(cpu_stall_o),
    .ready_irq_o(ready_irq_o), .busy_o(busy_o));

always #20 clock_i = ~clock_i;
// Oscillator period chosen off the clock grid on purpose
always #97 osc_i = ~osc_i;

////////////////////////////////////////////////////////////////
task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
        $display("Result: passed");
    else
        $display("Result: failed");
    $finish;
endtask

always @(posedge clock_i)
begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
        miscompares++;
        wrap_up;
    end
end

task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    n_checks++;
    // An unknown value on both sides must still count as a mismatch
    if (seen !== exp || $isunknown(seen))
    begin
        miscompares++;
        $display("Error %s expected %h seen %h", what, exp, seen);
    end
endtask

// A strobe stays up until the next wr, rd or idle call clears it
task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock_i);
    reg_re_i <= 1'b0;
    reg_we_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
endtask

task automatic idle;
    @(posedge clock_i);
    reg_we_i <= 1'b0;
    reg_re_i <= 1'b0;
endtask

task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clock_i);
    reg_we_i <= 1'b0;
    reg_re_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clock_i);
    reg_re_i <= 1'b0;
    #1 d = reg_rdata_o;
endtask

task automatic count_stall(input int exp);
    n = 0;
    while (cpu_stall_o === 1'b1 && n < 20)
    begin
        n++;
        @(posedge clock_i);
        #1;
    end
    check("stall cycles", 9'(n), 9'(exp));
endtask

task automatic wait_idle;
    n = 0;
    while (busy_o !== 1'b0 && n < 5000)
    begin
        n++;
        @(posedge clock_i);
        #1;
    end
    check("busy timeout", 9'(n >= 5000), 9'h000);
endtask

function automatic logic [7:0] ctl(input logic [1:0] m, input logic [2:0] b);
    return {2'b00, m, ie, b};
endfunction

// gap: idle cycles between arm and start; -1 arms and starts in one write
task automatic prog(input logic [1:0] m, input logic [8:0] a, input logic [7:0] d,
                    input int gap, input logic arm);
    logic taken;
    taken = arm && gap >= 0 && gap <= 3 && m != eeprom_pkg::MODE_RESERVED;
    wait_idle;
    wr(CT, ctl(m, 3'b000));
    wr(AL, a[7:0]);
    wr(AH, {7'h00, a[8]});
    wr(DT, d);
    if (arm && gap >= 0)
        wr(CT, ctl(m, 3'b100));
    repeat (gap > 0 ? gap : 0) idle;
    wr(CT, ctl(m, {arm, 2'b10}));
    idle;
    #1;
    check("busy after start", 9'(busy_o), 9'(taken));
    count_stall(taken ? 2 : 0);
    if (taken)
    begin
        case (m)
            eeprom_pkg::MODE_ATOMIC: model[a] = d;
            eeprom_pkg::MODE_ERASE: model[a] = eeprom_pkg::ERASED_BYTE;
            default: model[a] = model[a] & d;
        endcase
    end
endtask

task automatic readback(input logic [8:0] a);
    wait_idle;
    wr(AL, a[7:0]);
    wr(AH, {7'h00, a[8]});
    wr(CT, ctl(2'b00, 3'b001));
    idle;
    #1;
    count_stall(4);
    rd(DT, rv);
    check("array byte", {1'b0, rv}, {1'b0, model[a]});
endtask

////////////////////////////////////////////////////////////////
initial
begin
    void'($urandom(33));
    repeat (4) @(posedge clock_i);
    rst_n_i <= 1'b1;
    por_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    for (int r = 0; r < 4; r++)
    begin
        rd(2'(r), rv);
        check("reset value", {1'b0, rv}, 9'h000);
    end
    wr(AH, 8'hff);
    rd(AH, rv);
    check("addr high", {1'b0, rv}, 9'h001);
    $display("test registers done");

    ra = 9'h1a5;
    prog(eeprom_pkg::MODE_ERASE, ra, 8'h00, 0, 1'b1);
    wait_idle;
    t_split = n;
    readback(ra);
    prog(eeprom_pkg::MODE_WRITE, ra, 8'h5a, 3, 1'b1);
    readback(ra);
    prog(eeprom_pkg::MODE_WRITE, ra, 8'h0f, 0, 1'b1);
    readback(ra);
    prog(eeprom_pkg::MODE_ATOMIC, ra, 8'hc3, 1, 1'b1);
    wait_idle;
    check("atomic longer", 9'(n > t_split + 8), 9'h001);
    readback(ra);
    prog(eeprom_pkg::MODE_RESERVED, ra, 8'h00, 0, 1'b1);
    prog(eeprom_pkg::MODE_ATOMIC, ra, 8'h11, 4, 1'b1);
    prog(eeprom_pkg::MODE_ATOMIC, ra, 8'h22, 0, 1'b0);
    prog(eeprom_pkg::MODE_ATOMIC, ra, 8'h33, -1, 1'b1);
    readback(ra);
    $display("test modes and arm window done");

    ie = 1'b1;
    prog(eeprom_pkg::MODE_ERASE, 9'h010, 8'h00, 0, 1'b1);
    check("irq while busy", 9'(ready_irq_o), 9'h000);
    rd(CT, rv);
    check("ctrl busy bits", {1'b0, rv & 8'h3a}, 9'h01a);
    wr(CT, ctl(eeprom_pkg::MODE_WRITE, 3'b000));
    wr(AL, 8'h55);
    wr(CT, ctl(eeprom_pkg::MODE_WRITE, 3'b001));
    idle;
    #1;
    count_stall(0);
    rd(AL, rv);
    check("addr while busy", {1'b0, rv}, 9'h010);
    wr(CT, ctl(eeprom_pkg::MODE_WRITE, 3'b100));
    wr(CT, ctl(eeprom_pkg::MODE_WRITE, 3'b110));
    idle;
    rst_n_i <= 1'b0;
    @(posedge clock_i);
    rst_n_i <= 1'b1;
    ie = 1'b0;
    #1;
    check("busy over reset", 9'(busy_o), 9'h001);
    wait_idle;
    rd(CT, rv);
    check("mode kept", {1'b0, rv & 8'h30}, 9'h010);
    readback(9'h010);
    check("irq disabled", 9'(ready_irq_o), 9'h000);
    ie = 1'b1;
    wr(CT, ctl(2'b00, 3'b000));
    idle;
    #1;
    check("irq ready", 9'(ready_irq_o), 9'h001);
    $display("test busy refusal and reset done");

    repeat (12)
    begin
        ra = 9'($urandom_range(0, 511));
        // A never-programmed byte is unknown; erase it first so the compare means something
        if ($isunknown(model[ra]))
            prog(eeprom_pkg::MODE_ERASE, ra, 8'h00, 0, 1'b1);
        prog(2'($urandom_range(0, 2)), ra, 8'($urandom), $urandom_range(0, 3), 1'b1);
        readback(ra);
    end
    $display("test random programming done");
    wrap_up;
end
endmodule
`default_nettype wire
